// >>> desout_params.svh
// Constants for the deserializer output control block.
`ifndef DESOUT_PARAMS_SVH
`define DESOUT_PARAMS_SVH

`define DESOUT_WORD_W        10
`define DESOUT_SER_BITS      12
`define DESOUT_DATA_MSB      10
`define DESOUT_DATA_LSB      1
`define DESOUT_LOCK_NEED     4'h4
`define DESOUT_LOCK_DROP     4'h2
`define DESOUT_REF_MAX       16'h0040
`define DESOUT_REF_MIN       16'h0001

`define DESOUT_ADDR_CTRL     8'h00
`define DESOUT_ADDR_STATUS   8'h04
`define DESOUT_ADDR_IRQ_STAT 8'h08
`define DESOUT_ADDR_IRQ_MASK 8'h0C
`define DESOUT_ADDR_WORD     8'h10
`define DESOUT_ADDR_REFDIV   8'h14

`define DESOUT_CTRL_RESET    4'h0
`define DESOUT_MASK_RESET    3'h0
`define DESOUT_REFDIV_RESET  16'h0004

`define DESOUT_IRQ_LOCK      0
`define DESOUT_IRQ_UNLOCK    1
`define DESOUT_IRQ_WORD      2

`define DESOUT_RESP_OKAY     2'h0
`define DESOUT_RESP_SLVERR   2'h2

`endif

// >>> desout_pkg.sv
// Types for the deserializer output control block.
package desout_pkg;
  typedef logic [9:0] desout_word_t;
  typedef enum logic [1:0] {
    DESOUT_SLEEP    = 2'b00,
    DESOUT_HUNT     = 2'b01,
    DESOUT_LOCKED   = 2'b10
  } desout_state_t;
endpackage : desout_pkg

// >>> desout_ref_tick.sv
// Reference tick generator that divides aclk to set the recovery bit rate.
`timescale 1ns/1ps
`include "desout_params.svh"
module desout_ref_tick (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Control
  input  wire logic        run,
  input  wire logic [15:0] divide,
  // Tick
  output logic             tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q + 16'h0001 >= divide) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule : desout_ref_tick

// >>> desout_top.sv
// Deserializer output control: lock, recovered clock, word output and enables.
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "desout_params.svh"
// Functional notes
// - The edge select picks the recovered clock edge that strobes the word, high rising.
// - Power-down low stops the recovery loop and floats word, clock and lock outputs.
// - The active-low lock indicator goes low once locked and stays high otherwise.
// - A recovered clock runs at word rate and each word is timed to it.
// - Output enable low floats the word and clock while lock stays driven.
// - A driven lock indicator always shows the present lock state.
// - The recovered clock toggles only while locked.
// - While not locked, word and clock float even with both enables high.
// - The aclk tick divided by the REFDIV register sets the loop rate; the reference clock pin is only sampled into status.
module desout_top
  import desout_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Serial link and pins
  input  wire logic                  serial_in_pos,
  input  wire logic                  serial_in_neg,
  input  wire logic                  pll_reference_clock,
  input  wire logic                  power_down_n,
  input  wire logic                  output_enable,
  input  wire logic                  recovered_clock_edge_select,
  // Parallel side
  output desout_pkg::desout_word_t   parallel_word_out,
  output logic                       parallel_word_oe,
  output logic                       recovered_clock,
  output logic                       recovered_clock_oe,
  output logic                       lock_n,
  output logic                       lock_n_oe,
  // AXI4-Lite write
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Interrupt
  output logic                       irq
);
  import desout_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  desout_state_t state_q;
  logic [3:0]    ctrl_q;
  logic [2:0]    mask_q;
  logic [2:0]    stat_q;
  logic [15:0]   refdiv_q;
  logic          bit_tick;
  logic          ref_q;
  logic [11:0]   shift_q;
  logic [3:0]    bitcnt_q;
  logic [3:0]    good_q;
  logic [3:0]    bad_q;
  desout_word_t  word_q;
  logic          word_ev;
  logic          rclk_q;
  logic          rclk_phase_q;
  logic [7:0]    awaddr_q;
  logic [31:0]   wdata_q;
  logic [3:0]    wstrb_q;
  logic          aw_have_q;
  logic          w_have_q;
  logic          rd_stat_clr;
  logic          locked;
  logic          powered;
  logic          sym_ok;
  logic          ev_lock;
  logic          ev_unlock;
  logic          sw_pd;
  logic          sw_oe_off;
  logic [31:0]   ctrl_wr;
  logic [31:0]   mask_wr;
  logic [31:0]   refdiv_wr;

  // Byte-lane write merge, used by every writable register.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ************************************************************
  // Power and enables
  // ************************************************************
  // Software may force sleep or float outputs on top of the pins.
  assign sw_pd     = ctrl_q[0];
  assign sw_oe_off = ctrl_q[1];
  assign powered   = power_down_n && !sw_pd;
  assign locked    = (state_q == DESOUT_LOCKED);

  // ************************************************************
  // Reference tick and serial sampling
  // ************************************************************
  // The reference tick paces the bit sampler, so the loop runs at its rate.
  desout_ref_tick u_ref_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (powered),
    .divide  (refdiv_q),
    .tick    (bit_tick)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= pll_reference_clock;
    end
  end

  // A symbol is 12 bits: start bit high, ten data bits, stop bit low.
  assign sym_ok = shift_q[11] && !shift_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn || !powered) begin
      shift_q  <= 12'h000;
      bitcnt_q <= 4'h0;
    end else if (bit_tick) begin
      shift_q  <= {shift_q[10:0], serial_in_pos & ~serial_in_neg};
      // While hunting, a badly framed symbol end holds the count, so the next tick checks
      // the alignment one bit later. Any rising transition can frame, so the far end must
      // send words with a single rising transition until lock, or lock may be false.
      if (bitcnt_q == 4'(`DESOUT_SER_BITS - 1)) begin
        bitcnt_q <= (state_q == DESOUT_HUNT && !sym_ok) ? bitcnt_q : 4'h0;
      end else begin
        bitcnt_q <= bitcnt_q + 4'h1;
      end
    end
  end

  // ************************************************************
  // Lock state machine
  // ************************************************************
  // Lock needs several good embedded edges; a few bad ones drop it.
  always_ff @(posedge aclk) begin
    if (!aresetn || !powered) begin
      state_q <= DESOUT_SLEEP;
      good_q  <= 4'h0;
      bad_q   <= 4'h0;
    end else if (bit_tick && bitcnt_q == 4'(`DESOUT_SER_BITS - 1)) begin
      case (state_q)
        DESOUT_SLEEP: begin
          state_q <= DESOUT_HUNT;
        end
        DESOUT_HUNT: begin
          if (!sym_ok) begin
            good_q <= 4'h0;
          end else if (good_q + 4'h1 >= `DESOUT_LOCK_NEED) begin
            state_q <= DESOUT_LOCKED;
            bad_q   <= 4'h0;
          end else begin
            good_q <= good_q + 4'h1;
          end
        end
        DESOUT_LOCKED: begin
          if (sym_ok) begin
            bad_q <= 4'h0;
          end else if (bad_q + 4'h1 >= `DESOUT_LOCK_DROP) begin
            state_q <= DESOUT_HUNT;
            good_q  <= 4'h0;
          end else begin
            bad_q <= bad_q + 4'h1;
          end
        end
        default: begin
          state_q <= DESOUT_SLEEP;
        end
      endcase
    end else if (state_q == DESOUT_SLEEP) begin
      state_q <= DESOUT_HUNT;
    end
  end

  assign ev_lock   = bit_tick && bitcnt_q == 4'(`DESOUT_SER_BITS - 1) &&
                     state_q == DESOUT_HUNT && sym_ok && good_q + 4'h1 >= `DESOUT_LOCK_NEED;
  assign ev_unlock = bit_tick && bitcnt_q == 4'(`DESOUT_SER_BITS - 1) &&
                     state_q == DESOUT_LOCKED && !sym_ok && bad_q + 4'h1 >= `DESOUT_LOCK_DROP;

  // ************************************************************
  // Word capture and recovered clock
  // ************************************************************
  // One word per symbol while locked.
  assign word_ev = locked && bit_tick && bitcnt_q == 4'(`DESOUT_SER_BITS - 1) && sym_ok;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q <= 10'h000;
    end else if (word_ev) begin
      word_q <= shift_q[`DESOUT_DATA_MSB:`DESOUT_DATA_LSB];
    end
  end

  // The clock has one period per word; its strobing edge is set by the select pin,
  // so the word changes on the opposite edge and is stable at the strobing edge.
  always_ff @(posedge aclk) begin
    if (!aresetn || !locked) begin
      rclk_phase_q <= 1'b0;
    end else if (bit_tick && bitcnt_q == 4'(`DESOUT_SER_BITS / 2 - 1)) begin
      rclk_phase_q <= 1'b1;
    end else if (word_ev) begin
      rclk_phase_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !locked) begin
      rclk_q <= 1'b0;
    end else begin
      rclk_q <= rclk_phase_q ^ ~recovered_clock_edge_select;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      parallel_word_out <= 10'h000;
    end else begin
      parallel_word_out <= word_q;
    end
  end

  assign recovered_clock = rclk_q;
  // Drivers: lock floats only in sleep; word and clock need power, enable and lock.
  assign parallel_word_oe   = powered && output_enable && !sw_oe_off && locked;
  assign recovered_clock_oe = parallel_word_oe;
  assign lock_n_oe          = powered;
  assign lock_n             = !locked;

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // Set wins over the read clear so no event is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (rd_stat_clr ? 3'h0 : stat_q) | {word_ev, ev_unlock, ev_lock};
    end
  end

  assign irq = |(stat_q & mask_q);

  // ************************************************************
  // AXI4-Lite write
  // ************************************************************
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else if (aw_have_q && w_have_q) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DESOUT_RESP_OKAY;
    end else if (aw_have_q && w_have_q) begin
      s_axi_bvalid <= 1'b1;
      case ({awaddr_q[7:2], 2'b00})
        `DESOUT_ADDR_CTRL, `DESOUT_ADDR_IRQ_MASK, `DESOUT_ADDR_REFDIV: begin
          s_axi_bresp <= `DESOUT_RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= `DESOUT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign ctrl_wr   = merge({28'h0, ctrl_q}, wdata_q, wstrb_q);
  assign mask_wr   = merge({29'h0, mask_q}, wdata_q, wstrb_q);
  assign refdiv_wr = merge({16'h0, refdiv_q}, wdata_q, wstrb_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= `DESOUT_CTRL_RESET;
      mask_q   <= `DESOUT_MASK_RESET;
      refdiv_q <= `DESOUT_REFDIV_RESET;
    end else if (aw_have_q && w_have_q) begin
      case ({awaddr_q[7:2], 2'b00})
        `DESOUT_ADDR_CTRL: begin
          ctrl_q <= ctrl_wr[3:0];
        end
        `DESOUT_ADDR_IRQ_MASK: begin
          mask_q <= mask_wr[2:0];
        end
        `DESOUT_ADDR_REFDIV: begin
          refdiv_q <= refdiv_wr[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // AXI4-Lite read
  // ************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_stat_clr   = s_axi_arvalid && s_axi_arready &&
                         {s_axi_araddr[7:2], 2'b00} == `DESOUT_ADDR_IRQ_STAT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DESOUT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `DESOUT_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `DESOUT_ADDR_CTRL:     s_axi_rdata <= {28'h0, ctrl_q};
        `DESOUT_ADDR_STATUS:   s_axi_rdata <= {26'h0, ref_q, power_down_n, powered,
                                               parallel_word_oe, state_q};
        `DESOUT_ADDR_IRQ_STAT: s_axi_rdata <= {29'h0, stat_q};
        `DESOUT_ADDR_IRQ_MASK: s_axi_rdata <= {29'h0, mask_q};
        `DESOUT_ADDR_WORD:     s_axi_rdata <= {22'h0, word_q};
        `DESOUT_ADDR_REFDIV:   s_axi_rdata <= {16'h0, refdiv_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `DESOUT_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : desout_top

// >>> desout_ser_model.sv
// Far-end serializer model that feeds framed symbols into the serial input pair.
`timescale 1ns/1ps
module desout_ser_model #(
  parameter int BIT_CYCLES = 4
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control from the bench
  input  wire logic [9:0] word,
  input  wire logic       corrupt,
  // Serial pair
  output logic            serial_in_pos,
  output logic            serial_in_neg
);
  // ****************************************
  // Symbol shifter
  // ****************************************
  logic [11:0] sym_q;
  logic [3:0]  bit_q;
  logic [7:0]  cyc_q;

  // Each bit is held for one full bit tick, so the receiver samples it once at any phase.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_q <= 8'h00;
      bit_q <= 4'h0;
      sym_q <= 12'h000;
    end else if (cyc_q != BIT_CYCLES[7:0] - 8'h01) begin
      cyc_q <= cyc_q + 8'h01;
    end else begin
      cyc_q <= 8'h00;
      bit_q <= (bit_q == 4'hB) ? 4'h0 : bit_q + 4'h1;
      if (bit_q == 4'hB) begin
        // All ones never frames at any alignment, so a corrupt stream cannot relock.
        sym_q <= corrupt ? 12'hFFF : {1'b1, word, 1'b0};
      end else begin
        sym_q <= {sym_q[10:0], 1'b0};
      end
    end
  end

  assign serial_in_pos = sym_q[11];
  assign serial_in_neg = ~sym_q[11];
endmodule : desout_ser_model

// >>> desout_top_asserts.sv
// Concurrent checks on the output pins of the deserializer output control.
`timescale 1ns/1ps
module desout_top_asserts
  import desout_pkg::*;
(
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Pins
  input wire logic                power_down_n,
  input wire logic                output_enable,
  input desout_pkg::desout_word_t parallel_word_out,
  input wire logic                parallel_word_oe,
  input wire logic                recovered_clock,
  input wire logic                recovered_clock_oe,
  input wire logic                lock_n,
  input wire logic                lock_n_oe
);
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_new_word;
    $changed(parallel_word_out);
  endsequence
  sequence s_rclk_edge;
    $rose(recovered_clock);
  endsequence

  a_pd_floats: assert property (
    !power_down_n |-> !parallel_word_oe && !recovered_clock_oe && !lock_n_oe)
    else $error("outputs driven during power-down");
  a_oe_low_floats: assert property (
    !output_enable |-> !parallel_word_oe && !recovered_clock_oe)
    else $error("word or clock driven with enable low");
  a_unlock_floats: assert property (
    lock_n |-> !parallel_word_oe && !recovered_clock_oe)
    else $error("word or clock driven while unlocked");
  a_oe_needs_lock: assert property (
    parallel_word_oe |-> power_down_n && output_enable && !lock_n)
    else $error("word driven without power, enable and lock");
  a_clk_still: assert property (
    lock_n [*2] |-> !recovered_clock)
    else $error("recovered clock high while unlocked");
  a_rclk_locked: assert property (
    s_rclk_edge |-> !$past(lock_n))
    else $error("recovered clock rose without lock");
  a_rclk_rate: assert property (
    s_rclk_edge |=> (!$rose(recovered_clock)) [*8])
    else $error("recovered clock faster than word rate");
  a_word_held: assert property (
    s_new_word |=> $stable(parallel_word_out) [*8])
    else $error("word changed faster than one per symbol");
  a_lock_pd: assert property (
    $fell(power_down_n) |-> ##[0:2] lock_n)
    else $error("lock kept after power-down");
endmodule : desout_top_asserts

bind desout_top desout_top_asserts chk_u (
  .aclk(aclk), .aresetn(aresetn), .power_down_n(power_down_n),
  .output_enable(output_enable), .parallel_word_out(parallel_word_out),
  .parallel_word_oe(parallel_word_oe), .recovered_clock(recovered_clock),
  .recovered_clock_oe(recovered_clock_oe), .lock_n(lock_n), .lock_n_oe(lock_n_oe)
);

// >>> tb_deserializer_output_control.sv
// Self-checking testbench for the deserializer output control.
`timescale 1ns/1ps
module tb_deserializer_output_control;
  import desout_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic aclk = 1'b0, aresetn = 1'b0, serial_in_pos, serial_in_neg;
  logic pll_reference_clock = 1'b0, power_down_n = 1'b1, output_enable = 1'b1;
  logic recovered_clock_edge_select = 1'b1, corrupt = 1'b0;
  // A word with one rising transition frames at only one alignment while hunting.
  logic [9:0] tx_word = 10'h3F0;
  desout_word_t parallel_word_out;
  logic parallel_word_oe, recovered_clock, recovered_clock_oe, lock_n, lock_n_oe, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] q;
  int n_errors = 0, compares = 0, cycles = 0, r;

  desout_top dut_u (.*);
  desout_ser_model #(.BIT_CYCLES(4)) ser_u (.aclk(aclk), .aresetn(aresetn), .word(tx_word),
    .corrupt(corrupt), .serial_in_pos(serial_in_pos), .serial_in_neg(serial_in_neg));

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    pll_reference_clock <= ~pll_reference_clock;
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic pins(input logic [2:0] e);
    repeat (3) @(negedge aclk);
    chk(32'({parallel_word_oe, recovered_clock_oe, lock_n_oe}), 32'(e));
  endtask : pins

  task automatic wait_lock(input logic lvl);
    int n;
    n = 0;
    while (lock_n !== lvl && n < 2000) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(lock_n), 32'(lvl));
  endtask : wait_lock

  task automatic rises(input int cyc);
    logic p;
    r = 0;
    p = recovered_clock;
    repeat (cyc) begin
      @(negedge aclk);
      if (recovered_clock && !p) r++;
      p = recovered_clock;
    end
  endtask : rises

  // Ready is combinational from registers, so it is settled at the falling edge.
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tar, tr;
    n = 0;
    rsp = 2'h3;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tar = s_axi_arvalid && s_axi_arready;
      tr = (s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid);
      if (tr) begin
        q = s_axi_rdata;
        rsp = wr ? s_axi_bresp : s_axi_rresp;
      end
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tar) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_bready <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      n++;
    end while (!tr && n < 200);
    chk(32'(tr), 32'h1);
  endtask : axi

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_powerup();
    int n;
    pins(3'b001);
    chk(32'(lock_n), 32'h1);
    wait_lock(1'b0);
    repeat (100) @(negedge aclk);
    pins(3'b111);
    chk(32'(parallel_word_out), 32'h3F0);
    rises(96);
    chk(32'(r >= 1 && r <= 3), 32'h1);
    @(posedge aclk);
    recovered_clock_edge_select <= 1'b0;
    tx_word <= 10'h15A;
    n = 0;
    while (parallel_word_out !== 10'h15A && n < 200) begin
      @(negedge aclk);
      n++;
    end
    // Falling edge strobes, so the clock rises together with the new word.
    chk(32'(recovered_clock), 32'h1);
    repeat (150) @(negedge aclk);
    chk(32'(parallel_word_out), 32'h15A);
    @(posedge aclk);
    recovered_clock_edge_select <= 1'b1;
  endtask : t_powerup

  // The word event fires every symbol, so only lock and unlock are unmasked here.
  task automatic t_regs();
    chk(32'(irq), 32'h0);
    axi(1'b1, 8'h0C, 32'h3);
    chk(32'(rsp), 32'h0);
    pins(3'b111);
    chk(32'(irq), 32'h1);
    axi(1'b0, 8'h08, 32'h0);
    chk(q & 32'h3, 32'h1);
    pins(3'b111);
    chk(32'(irq), 32'h0);
    axi(1'b0, 8'h10, 32'h0);
    chk(q, 32'h15A);
    axi(1'b0, 8'h1C, 32'h0);
    chk({q[29:0], rsp}, 32'h2);
  endtask : t_regs

  task automatic t_enable();
    output_enable <= 1'b0;
    pins(3'b001);
    chk(32'(lock_n), 32'h0);
    @(posedge aclk);
    output_enable <= 1'b1;
    pins(3'b111);
    axi(1'b1, 8'h00, 32'h2);
    chk(32'(rsp), 32'h0);
    pins(3'b001);
    axi(1'b1, 8'h00, 32'h0);
    pins(3'b111);
  endtask : t_enable

  task automatic t_unlock();
    @(posedge aclk);
    corrupt <= 1'b1;
    wait_lock(1'b1);
    pins(3'b001);
    rises(100);
    chk(32'(r), 32'h0);
    @(posedge aclk);
    corrupt <= 1'b0;
    tx_word <= 10'h3F0;
    wait_lock(1'b0);
  endtask : t_unlock

  task automatic t_power_down();
    @(posedge aclk);
    power_down_n <= 1'b0;
    pins(3'b000);
    @(posedge aclk);
    power_down_n <= 1'b1;
    pins(3'b001);
    wait_lock(1'b0);
    pins(3'b111);
  endtask : t_power_down

  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_powerup();
    t_regs();
    t_enable();
    t_unlock();
    t_power_down();
    tally_and_finish();
  end
endmodule : tb_deserializer_output_control
